// File: sbt_pkg.sv
/*
  Package for the sixteen-bit interval timer: register byte addresses,
  field positions, reset values and the packed carrier types.
  Assumes a single 250 MHz bus clock and word-aligned AHB-Lite access.
*/
package sbt_pkg;

  // ****************************************************************
  // Register map (printed offsets are not all multiples of four).
  // ****************************************************************
  localparam logic [7:0] IDX_COUNT_LOW = 8'h00_b1;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'h00_b2;
  localparam logic [7:0] IDX_CLK_SRC = 8'h00_d8;
  localparam logic [7:0] IDX_MODE = 8'h00_dc;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h00_e0;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h00_e1;
  localparam logic [7:0] IDX_CTRL = 8'h00_e2;
  localparam logic [9:0] ADDR_COUNT_LOW = {IDX_COUNT_LOW, 2'b00};
  localparam logic [9:0] ADDR_COUNT_HIGH = {IDX_COUNT_HIGH, 2'b00};
  localparam logic [9:0] ADDR_CLK_SRC = {IDX_CLK_SRC, 2'b00};
  localparam logic [9:0] ADDR_MODE = {IDX_MODE, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] ADDR_IRQ_MASK = {IDX_IRQ_MASK, 2'b00};
  localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int BIT_RUN = 7;
  localparam int BIT_RATE_LO = 4;
  localparam int BIT_RELOAD = 3;
  localparam int BIT_CAPT = 2;
  localparam int BIT_OVF = 1;
  localparam int BIT_FAST = 3;
  localparam int BIT_ALT = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00_00;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [7:0] PRESCALE_ONES = 8'h00_ff;

  // Mode register fields.
  typedef struct packed {
    logic run;
    logic [2:0] rate;
    logic reload;
    logic capt;
    logic ovf;
    logic spare;
  } sbt_mode_t;

  // Bus address phase captured for the data phase.
  typedef struct packed {
    logic valid;
    logic write;
    logic [9:0] addr;
  } sbt_req_t;

  // Bus handshake states (Gray coded).
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DATA = 2'b01
  } sbt_state_t;

endpackage

// File: sbt_timer.sv
/*
  Sixteen-bit interval timer with AHB-Lite register slave and a level
  interrupt. Assumes hclk at 250 MHz; prescale ticks are made from hclk
  (the instruction clock is hclk/4 here, the fast oscillator is twice hclk).
*/
module sbt_timer (
  // Clock, reset and enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // System events.
  output logic irq,
  output logic timeout_pulse,
  output logic wake_req
);

  // ****************************************************************
  // State.
  // ****************************************************************
  sbt_pkg::sbt_mode_t mode_q, mode_d;
  logic [7:0] clk_src_q, clk_src_d;
  logic [15:0] count_q, count_d;
  logic [15:0] reload_q, reload_d;
  logic [7:0] high_latch_q, high_latch_d;
  logic [7:0] irq_sta_q, irq_sta_d;
  logic [7:0] irq_msk_q, irq_msk_d;
  logic alt_q, alt_d;
  logic [9:0] pre_q, pre_d;
  sbt_pkg::sbt_req_t req_q, req_d;
  sbt_pkg::sbt_state_t st_q, st_d;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d, to_q, to_d, wake_q, wake_d;
  logic tick, ovf_evt, wr, lo_take;
  logic [7:0] wb;
  logic [7:0] tap;
  logic [9:0] mask;

  // Write strobes happen in the data phase of a taken request; reads are sampled at its address phase.
  assign wr = req_q.valid & req_q.write;
  // A low byte read is seen at its address phase, the same edge that samples the low byte.
  assign lo_take = hsel & hready & htrans[1] & ~hwrite & (haddr[9:0] == sbt_pkg::ADDR_COUNT_LOW);
  assign wb = hwdata[7:0];

  // ****************************************************************
  // Prescaler.
  // ****************************************************************
  // The slow source is hclk/4, so its mask carries two extra low bits; a tick
  // comes once every mask+1 cycles, counted from the prescaler's clear.
  always_comb begin
    tap = sbt_pkg::PRESCALE_ONES >> mode_q.rate;
    if (!clk_src_q[sbt_pkg::BIT_FAST]) begin
      mask = {tap, 2'b11};
    end else begin
      mask = {3'b000, tap[7:1]};
    end
    tick = (pre_q & mask) == mask;
  end

  // ****************************************************************
  // Counter, flags and registers.
  // ****************************************************************
  // One next-state block for all software-visible state.
  always_comb begin
    mode_d = mode_q;
    clk_src_d = clk_src_q;
    count_d = count_q;
    reload_d = reload_q;
    high_latch_d = high_latch_q;
    irq_sta_d = irq_sta_q;
    irq_msk_d = irq_msk_q;
    alt_d = alt_q;
    pre_d = pre_q;
    ovf_evt = 1'b0;
    // Counting is gated by run, and suppressed in sensing mode.
    if (mode_q.run && !alt_q) begin
      pre_d = pre_q + 10'h001;
      if (mode_q.capt) begin
        count_d = 16'h0000;
        mode_d.capt = 1'b0;
        pre_d = '0;
      end else if (tick) begin
        if (count_q == sbt_pkg::COUNT_MAX) begin
          ovf_evt = 1'b1;
          count_d = mode_q.reload ? reload_q : 16'h0000;
        end else begin
          count_d = count_q + 16'h0001;
        end
      end
    end else begin
      pre_d = '0;
    end
    // Latching with the low byte's sample keeps the pair from straddling a carry.
    if (lo_take) begin
      high_latch_d = count_q[15:8];
    end
    if (wr) begin
      case (req_q.addr)
        sbt_pkg::ADDR_COUNT_HIGH: begin
          count_d[15:8] = wb;
          reload_d[15:8] = wb;
        end
        sbt_pkg::ADDR_COUNT_LOW: begin
          count_d[7:0] = wb;
          reload_d[7:0] = wb;
        end
        sbt_pkg::ADDR_MODE: begin
          mode_d = wb;
          mode_d.ovf = mode_q.ovf & wb[sbt_pkg::BIT_OVF];
        end
        sbt_pkg::ADDR_CLK_SRC: clk_src_d = wb;
        sbt_pkg::ADDR_IRQ_STATUS: irq_sta_d = irq_sta_q & ~wb;
        sbt_pkg::ADDR_IRQ_MASK: irq_msk_d = wb;
        sbt_pkg::ADDR_CTRL: alt_d = wb[sbt_pkg::BIT_ALT];
        default: begin
        end
      endcase
    end
    // Hardware set wins over a same-cycle software clear.
    if (ovf_evt) begin
      mode_d.ovf = 1'b1;
      irq_sta_d[0] = 1'b1;
    end
  end

  // Register stage for software-visible state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= sbt_pkg::RESET_BYTE;
      clk_src_q <= sbt_pkg::RESET_BYTE;
      count_q <= 16'h0000;
      reload_q <= 16'h0000;
      high_latch_q <= sbt_pkg::RESET_BYTE;
      irq_sta_q <= sbt_pkg::RESET_BYTE;
      irq_msk_q <= sbt_pkg::RESET_BYTE;
      alt_q <= 1'b0;
      pre_q <= '0;
    end else if (clk_en) begin
      mode_q <= mode_d;
      clk_src_q <= clk_src_d;
      count_q <= count_d;
      reload_q <= reload_d;
      high_latch_q <= high_latch_d;
      irq_sta_q <= irq_sta_d;
      irq_msk_q <= irq_msk_d;
      alt_q <= alt_d;
      pre_q <= pre_d;
    end
  end

  // ****************************************************************
  // AHB-Lite slave and outputs.
  // ****************************************************************
  // Zero-wait slave: read data is registered at the address phase edge.
  always_comb begin
    req_d.valid = hsel & hready & htrans[1];
    req_d.write = hwrite;
    req_d.addr = haddr[9:0];
    st_d = req_d.valid ? sbt_pkg::ST_DATA : sbt_pkg::ST_IDLE;
    rdata_d = 32'h0000_0000;
    if (req_d.valid && !hwrite) begin
      case (haddr[9:0])
        sbt_pkg::ADDR_COUNT_LOW: rdata_d[7:0] = count_q[7:0];
        sbt_pkg::ADDR_COUNT_HIGH: rdata_d[7:0] = high_latch_q;
        sbt_pkg::ADDR_MODE: rdata_d[7:0] = mode_q;
        sbt_pkg::ADDR_CLK_SRC: rdata_d[7:0] = clk_src_q;
        sbt_pkg::ADDR_IRQ_STATUS: rdata_d[7:0] = irq_sta_q;
        sbt_pkg::ADDR_IRQ_MASK: rdata_d[7:0] = irq_msk_q;
        sbt_pkg::ADDR_CTRL: rdata_d[7:0] = {7'b000_0000, alt_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    irq_d = |(irq_sta_d & irq_msk_d);
    to_d = ovf_evt;
    wake_d = mode_d.run & irq_d;
  end

  // Register stage for the bus and the outputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
      st_q <= sbt_pkg::ST_IDLE;
      rdata_q <= 32'h0000_0000;
      irq_q <= 1'b0;
      to_q <= 1'b0;
      wake_q <= 1'b0;
    end else if (clk_en) begin
      req_q <= req_d;
      st_q <= st_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
      to_q <= to_d;
      wake_q <= wake_d;
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = irq_q;
  assign timeout_pulse = to_q;
  assign wake_req = wake_q;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  property p_stop;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && !mode_q.run && !wr) |=> $stable(count_q);
  endproperty
  a_stop: assert property (p_stop) else $error("count moved while stopped");

  property p_ovf;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && ovf_evt) |=> mode_q.ovf && irq_sta_q[0];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not set");

  property p_reload;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && ovf_evt && mode_q.reload && !wr) |=> count_q == $past(reload_q);
  endproperty
  a_reload: assert property (p_reload) else $error("reload value wrong");

  property p_wrap;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && ovf_evt && !mode_q.reload && !wr) |=> count_q == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("count did not wrap");

  property p_capt;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && mode_q.run && !alt_q && mode_q.capt && !wr) |=> count_q == 16'h0000 && !mode_q.capt;
  endproperty
  a_capt: assert property (p_capt) else $error("capture start not handled");

  property p_sticky;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && mode_q.ovf && !wr) |=> mode_q.ovf;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped");

  property p_irq;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && ovf_evt && irq_msk_q[0] && !wr) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");

  property p_alt;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && alt_q && !wr) |=> $stable(count_q);
  endproperty
  a_alt: assert property (p_alt) else $error("counted in sensing mode");

  property p_freeze;
    @(posedge hclk) disable iff (!hresetn)
    !clk_en |=> $stable(count_q) && $stable(mode_q) && $stable(pre_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with clock enable low");

  property p_latch;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && lo_take) |=> high_latch_q == $past(count_q[15:8]);
  endproperty
  a_latch: assert property (p_latch) else $error("high byte latch not coherent");

  property p_pulse;
    @(posedge hclk) disable iff (!hresetn)
    (clk_en && ovf_evt) |=> timeout_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("time-out pulse missing");

  property p_wake;
    @(posedge hclk) disable iff (!hresetn)
    clk_en |=> wake_req == (mode_q.run & irq);
  endproperty
  a_wake: assert property (p_wake) else $error("wake request wrong");

  c_ovf: cover property (@(posedge hclk) ovf_evt);
  c_reload: cover property (@(posedge hclk) ovf_evt && mode_q.reload);
  c_irq: cover property (@(posedge hclk) $rose(irq));
  c_capt: cover property (@(posedge hclk) mode_q.run && mode_q.capt);

endmodule

// File: sbt_timer_test.sv
/*
  Self-checking bench for the interval timer: register traffic over AHB-Lite
  single word transfers, with expectations worked out from the mode fields.
  Assumes the timer package and module; hready is looped from hreadyout.
*/
module sbt_timer_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Signals and the design.
  // ****************************************************************
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic clk_en = 1'h1;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic timeout_pulse;
  logic wake_req;
  logic [7:0] rd;
  int err_count = 0;
  int checks_done = 0;
  int n;
  int d;
  // A 2 ns half period gives the 250 MHz bus clock.
  always #2 hclk = ~hclk;
  sbt_timer DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .timeout_pulse(timeout_pulse), .wake_req(wake_req));
  // ****************************************************************
  // Bus tasks and comparison.
  // ****************************************************************
  // Waits for hready high; only the watchdog ends a stuck wait.
  task automatic wait_rdy;
    @(posedge hclk);
    while (hreadyout !== 1'h1) begin
      @(posedge hclk);
    end
  endtask
  // Outputs are registered, so reading them right at the edge sees settled data.
  task automatic xfer(input logic [9:0] a, input logic w, input logic [7:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    haddr <= {22'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, wd};
    wait_rdy();
    rd = hrdata[7:0];
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    xfer(a, 1'h1, v);
  endtask
  task automatic rc(input logic [9:0] a, input logic [7:0] exp);
    xfer(a, 1'h0, 8'h00);
    chk(rd, exp);
    chk({7'h00, hresp}, 8'h00);
  endtask
  // Preloads the count just below wrap and runs until the time-out pulse.
  task automatic start(input logic fast, input logic [2:0] rate, input logic [7:0] lo,
    input logic [3:0] md);
    wr(sbt_pkg::ADDR_MODE, 8'h00);
    wr(sbt_pkg::ADDR_COUNT_HIGH, 8'hff);
    wr(sbt_pkg::ADDR_COUNT_LOW, lo);
    wr(sbt_pkg::ADDR_CLK_SRC, {4'h0, fast, 3'h0});
    wr(sbt_pkg::ADDR_MODE, {1'h1, rate, md});
    n = 0;
    while (timeout_pulse !== 1'h1 && n < 5000) begin
      @(posedge hclk);
      n++;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ****************************************************************
  // Tests.
  // ****************************************************************
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    // Reset contents, then an unmapped word that must stay zero.
    rc(sbt_pkg::ADDR_COUNT_LOW, 8'h00);
    rc(sbt_pkg::ADDR_COUNT_HIGH, 8'h00);
    rc(sbt_pkg::ADDR_CLK_SRC, 8'h00);
    rc(sbt_pkg::ADDR_MODE, 8'h00);
    wr(10'h3fc, 8'hff);
    rc(10'h3fc, 8'h00);
    // A stopped counter keeps its loaded value.
    wr(sbt_pkg::ADDR_COUNT_HIGH, 8'ha5);
    wr(sbt_pkg::ADDR_COUNT_LOW, 8'h3c);
    repeat (20) @(posedge hclk);
    rc(sbt_pkg::ADDR_COUNT_LOW, 8'h3c);
    rc(sbt_pkg::ADDR_COUNT_HIGH, 8'ha5);
    // Four ticks to wrap for every source and rate; the prescaler starts from the clear done by the mode 00 write.
    for (int f = 0; f < 2; f++) begin
      for (int r = 0; r < 8; r++) begin
        start(f[0], r[2:0], 8'hfc, 4'h0);
        d = f ? (128 >> r) : 4 * (256 >> r);
        chk({7'h00, n >= 3 * d && n <= 4 * d + 8}, 8'h01);
        @(posedge hclk);
        chk({7'h00, timeout_pulse}, 8'h00);
      end
    end
    // Without reload the count wrapped to zero; the interrupt is still masked.
    rc(sbt_pkg::ADDR_MODE, 8'hf2);
    xfer(sbt_pkg::ADDR_COUNT_LOW, 1'h0, 8'h00);
    rc(sbt_pkg::ADDR_COUNT_HIGH, 8'h00);
    chk({7'h00, irq}, 8'h00);
    rc(sbt_pkg::ADDR_IRQ_STATUS, 8'h01);
    wr(sbt_pkg::ADDR_IRQ_MASK, 8'h01);
    repeat (3) @(posedge hclk);
    chk({7'h00, irq}, 8'h01);
    chk({7'h00, wake_req}, 8'h01);
    rc(sbt_pkg::ADDR_MODE, 8'hf2);
    wr(sbt_pkg::ADDR_MODE, 8'h70);
    repeat (3) @(posedge hclk);
    chk({7'h00, wake_req}, 8'h00);
    rc(sbt_pkg::ADDR_MODE, 8'h70);
    wr(sbt_pkg::ADDR_IRQ_STATUS, 8'h01);
    repeat (3) @(posedge hclk);
    chk({7'h00, irq}, 8'h00);
    // Reload brings back the loaded value instead of zero.
    start(1'h1, 3'h7, 8'hf0, 4'h8);
    xfer(sbt_pkg::ADDR_COUNT_LOW, 1'h0, 8'h00);
    rc(sbt_pkg::ADDR_COUNT_HIGH, 8'hff);
    // Capture-start clears the count and reads back zero once done.
    wr(sbt_pkg::ADDR_MODE, 8'h00);
    wr(sbt_pkg::ADDR_COUNT_HIGH, 8'h12);
    wr(sbt_pkg::ADDR_COUNT_LOW, 8'h34);
    wr(sbt_pkg::ADDR_MODE, 8'hf4);
    rc(sbt_pkg::ADDR_MODE, 8'hf0);
    xfer(sbt_pkg::ADDR_COUNT_LOW, 1'h0, 8'h00);
    rc(sbt_pkg::ADDR_COUNT_HIGH, 8'h00);
    // Sensing mode holds the timer; leaving it lets it count again.
    wr(sbt_pkg::ADDR_MODE, 8'h00);
    wr(sbt_pkg::ADDR_CTRL, 8'h01);
    wr(sbt_pkg::ADDR_COUNT_HIGH, 8'h56);
    wr(sbt_pkg::ADDR_COUNT_LOW, 8'h78);
    wr(sbt_pkg::ADDR_MODE, 8'hf0);
    repeat (40) @(posedge hclk);
    rc(sbt_pkg::ADDR_COUNT_LOW, 8'h78);
    rc(sbt_pkg::ADDR_COUNT_HIGH, 8'h56);
    wr(sbt_pkg::ADDR_CTRL, 8'h00);
    repeat (300) @(posedge hclk);
    xfer(sbt_pkg::ADDR_COUNT_LOW, 1'h0, 8'h00);
    rc(sbt_pkg::ADDR_COUNT_HIGH, 8'h57);
    // Clock enable low freezes the running count; 400 free cycles would carry the high byte.
    clk_en <= 1'h0;
    repeat (400) @(posedge hclk);
    clk_en <= 1'h1;
    xfer(sbt_pkg::ADDR_COUNT_LOW, 1'h0, 8'h00);
    rc(sbt_pkg::ADDR_COUNT_HIGH, 8'h57);
    tally_and_finish();
  end
  // The tests need about 10k cycles; this limit leaves ample room.
  initial begin
    #200000;
    err_count++;
    $display("[FAIL] %0t: watchdog expired", $time);
    tally_and_finish();
  end
endmodule
